// ==== shared/sdm_regs.svh ====
// constants of the synchronous dram device model
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

`define SDM_BANKS      4
`define SDM_ROWS       4096
`define SDM_COLS       256
`define SDM_WORDS      (`SDM_BANKS * `SDM_ROWS * `SDM_COLS)
`define SDM_DQ_W       16
`define SDM_BUF_DEPTH  2
`define SDM_AP_BIT     10

`define SDM_MODE_RST   12'h020

`define SDM_BL_1       3'h0
`define SDM_BL_2       3'h1
`define SDM_BL_4       3'h2
`define SDM_BL_8       3'h3
`define SDM_BL_FULL    3'h7
`define SDM_MASK_1     8'h00
`define SDM_MASK_2     8'h01
`define SDM_MASK_4     8'h03
`define SDM_MASK_8     8'h07
`define SDM_MASK_FULL  8'hFF

`define SDM_CL_3       3'h3
`define SDM_OPM_NORMAL 2'h0

`endif

// ==== shared/sdm_pkg.sv ====
// types of the synchronous dram device model
package sdm_pkg;

  typedef enum logic [2:0] {
    SDM_C_LMR = 3'b000,
    SDM_C_REF = 3'b001,
    SDM_C_PRE = 3'b010,
    SDM_C_ACT = 3'b011,
    SDM_C_WR  = 3'b100,
    SDM_C_RD  = 3'b101,
    SDM_C_BST = 3'b110,
    SDM_C_NOP = 3'b111
  } sdm_cmd_e;

  typedef enum logic [1:0] {
    SDM_S_IDLE = 2'b00,
    SDM_S_RD   = 2'b01,
    SDM_S_WR   = 2'b10
  } sdm_state_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdm_ctl_s;

  typedef struct packed {
    logic [1:0] reserved;
    logic       write_burst_single_bit;
    logic       operating_mode_bit_high;
    logic       operating_mode_bit_low;
    logic [2:0] read_latency_field;
    logic       burst_order_bit;
    logic [2:0] burst_length_field;
  } sdm_mode_s;

  typedef logic [15:0] sdm_word_t;

endpackage

// ==== src/sdm_buf2.sv ====
// small valid/ready buffer in the read data path
`timescale 1ns/1ps
module sdm_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic             i_flush,
  // fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int          PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] slot_r [0:DEPTH-1];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [PW:0]      cnt_r;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
  endfunction

  // a full buffer still takes a word when one leaves in the same cycle
  assign o_ready = (cnt_r != FULL) || i_ready;
  assign o_valid = (cnt_r != '0);
  assign o_data  = slot_r[rp_r];
  assign push    = i_valid && o_ready && !i_flush;
  assign pop     = o_valid && i_ready && !i_flush;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (i_flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= bump(wp_r);
      end
      if (pop) begin
        rp_r <= bump(rp_r);
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      slot_r[wp_r] <= i_data;
    end
  end
endmodule // sdm_buf2

// ==== src/sdm_core.sv ====
// synchronous dram device: command decode, mode register, banks, burst engine
`timescale 1ns/1ps
`include "sdm_regs.svh"
// Functional notes
// - all inputs except the asynchronous reset i_nrst are sampled only on the rising clock edge
// - four banks of 4096 rows by 256 columns of 16-bit words
// - reads and writes need an open row from a prior ACTIVE
// - ACTIVE takes bank from bank selects and row from address 11..0
// - READ or WRITE takes starting column from address 7..0
// - mode register holds until the next mode load command
// - mode fields: length, order, latency, operating mode, write burst, reserved
// - lengths 1, 2, 4, 8 both orders; full page sequential only
// - burst length caps the columns one READ or WRITE touches
// - bursts wrap inside an aligned block of the burst length
// - full page bursts increment, wrap in the page, end by terminate
// - burst order bit picks sequential or interleaved order
// - sequential adds beat modulo length; interleaved xors beat with start
// - read latency of two or three clocks
// - read at edge n drives from edge n+m-1, valid at edge n+m
// - reads and writes run only in normal operating mode
// - write burst bit set makes each write a single location
module sdm_core (
  // clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_nrst,
  // command and address
  input  wire logic               i_cke,
  input  wire sdm_pkg::sdm_ctl_s  i_ctl,
  input  wire logic               i_bank_select_low,
  input  wire logic               i_bank_select_high,
  input  wire logic [11:0]        i_addr,
  input  wire logic               i_dqm,
  // data pins
  input  wire sdm_pkg::sdm_word_t i_dq,
  output sdm_pkg::sdm_word_t      o_dq,
  output logic                    o_dq_oe_n
);
  sdm_pkg::sdm_mode_s  mode_r;
  sdm_pkg::sdm_state_e st_r;
  sdm_pkg::sdm_cmd_e   cmd;
  sdm_pkg::sdm_word_t  mem_r [0:`SDM_WORDS-1];
  sdm_pkg::sdm_word_t  buf_dat;

  wire  [`SDM_BANKS-1:0][11:0] row_w;
  wire  [`SDM_BANKS-1:0]       open_w;
  logic [1:0]  ba;
  logic [1:0]  bank_r;
  logic [1:0]  c_bank;
  logic [7:0]  start_r;
  logic [7:0]  beat_r;
  logic [7:0]  len_r;
  logic [7:0]  c_start;
  logic [7:0]  c_beat;
  logic [7:0]  c_len;
  logic [7:0]  go_len;
  logic [7:0]  cur_col;
  logic [21:0] idx;
  logic        ilv_r;
  logic        fp_r;
  logic        c_ilv;
  logic        c_fp;
  logic        c_rd;
  logic        go_ilv;
  logic        go_fp;
  logic        take;
  logic        normal;
  logic        cl3;
  logic        rd_go;
  logic        wr_go;
  logic        go;
  logic        act_go;
  logic        pre_go;
  logic        lmr_go;
  logic        stop;
  logic        active;
  logic        adv;
  logic        last;
  logic        rd_push;
  logic        wr_beat;
  logic        buf_rdy;
  logic        buf_vld;
  logic        pop_rdy;
  logic        quiet;
  logic [1:0]  push_sr_r;
  logic        dqm_d1_r;

  function automatic logic [7:0] bl_mask(input logic [2:0] code);
    unique case (code)
      `SDM_BL_1:    bl_mask = `SDM_MASK_1;
      `SDM_BL_2:    bl_mask = `SDM_MASK_2;
      `SDM_BL_4:    bl_mask = `SDM_MASK_4;
      `SDM_BL_8:    bl_mask = `SDM_MASK_8;
      `SDM_BL_FULL: bl_mask = `SDM_MASK_FULL;
      // reserved codes fall back to single access
      default:      bl_mask = `SDM_MASK_1;
    endcase
  endfunction

  function automatic logic [7:0] beat_col(input logic [7:0] s, input logic [7:0] b,
                                          input logic [7:0] m, input logic il);
    logic [7:0] low;
    low      = il ? (s ^ b) : 8'(s + b);
    beat_col = (s & ~m) | (low & m);
  endfunction

  // command decode; a low clock gate freezes the whole device except the mask delay register dqm_d1_r
  assign take   = i_cke;
  assign ba     = {i_bank_select_high, i_bank_select_low};
  assign cmd    = i_ctl.cs_n ? sdm_pkg::SDM_C_NOP
                : sdm_pkg::sdm_cmd_e'({i_ctl.ras_n, i_ctl.cas_n, i_ctl.we_n});
  assign quiet  = take && (cmd == sdm_pkg::SDM_C_NOP);
  assign normal = ({mode_r.operating_mode_bit_high, mode_r.operating_mode_bit_low}
                   == `SDM_OPM_NORMAL);
  assign cl3    = (mode_r.read_latency_field == `SDM_CL_3);
  assign rd_go  = take && (cmd == sdm_pkg::SDM_C_RD) && open_w[ba] && normal;
  assign wr_go  = take && (cmd == sdm_pkg::SDM_C_WR) && open_w[ba] && normal;
  assign go     = rd_go || wr_go;
  assign act_go = take && (cmd == sdm_pkg::SDM_C_ACT);
  assign pre_go = take && (cmd == sdm_pkg::SDM_C_PRE);
  assign lmr_go = take && (cmd == sdm_pkg::SDM_C_LMR);
  assign stop   = (take && cmd == sdm_pkg::SDM_C_BST)
                || (pre_go && (i_addr[`SDM_AP_BIT] || ba == bank_r));

  // burst shape taken from the mode register at the command
  assign go_fp  = (mode_r.burst_length_field == `SDM_BL_FULL)
                  && !(wr_go && mode_r.write_burst_single_bit);
  assign go_ilv = mode_r.burst_order_bit && !go_fp;
  assign go_len = (wr_go && mode_r.write_burst_single_bit) ? `SDM_MASK_1
                : bl_mask(mode_r.burst_length_field);

  assign c_start = go ? i_addr[7:0] : start_r;
  assign c_bank  = go ? ba : bank_r;
  assign c_beat  = go ? 8'h00 : beat_r;
  assign c_len   = go ? go_len : len_r;
  assign c_ilv   = go ? go_ilv : ilv_r;
  assign c_fp    = go ? go_fp : fp_r;
  assign c_rd    = go ? rd_go : (st_r == sdm_pkg::SDM_S_RD);
  assign active  = go || (take && !stop && st_r != sdm_pkg::SDM_S_IDLE);
  assign cur_col = beat_col(c_start, c_beat, c_len, c_ilv);
  assign last    = (c_beat == c_len) && !c_fp;
  assign adv     = active && (!c_rd || buf_rdy);
  assign rd_push = active && c_rd;
  assign wr_beat = active && !c_rd && !i_dqm;
  assign idx     = {c_bank, row_w[c_bank], cur_col};

  // one open-row tracker per bank
  for (genvar g = 0; g < `SDM_BANKS; g++) begin : g_bank
    logic        open_r;
    logic [11:0] row_r;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
        open_r <= 1'b0;
        row_r  <= 12'h000;
      end else if (act_go && ba == 2'(g)) begin
        open_r <= 1'b1;
        row_r  <= i_addr;
      end else if (pre_go && (i_addr[`SDM_AP_BIT] || ba == 2'(g))) begin
        open_r <= 1'b0;
      end
    end
    assign open_w[g] = open_r;
    assign row_w[g]  = row_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_r <= sdm_pkg::sdm_mode_s'(`SDM_MODE_RST);
    end else if (lmr_go) begin
      mode_r <= sdm_pkg::sdm_mode_s'(i_addr);
    end
  end

  // burst engine; a read beat waits while the buffer refuses it
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r    <= sdm_pkg::SDM_S_IDLE;
      start_r <= 8'h00;
      beat_r  <= 8'h00;
      len_r   <= 8'h00;
      bank_r  <= 2'h0;
      ilv_r   <= 1'b0;
      fp_r    <= 1'b0;
    end else if (active) begin
      start_r <= c_start;
      bank_r  <= c_bank;
      len_r   <= c_len;
      ilv_r   <= c_ilv;
      fp_r    <= c_fp;
      beat_r  <= adv ? 8'(c_beat + 8'h01) : c_beat;
      st_r    <= (adv && last) ? sdm_pkg::SDM_S_IDLE
               : (c_rd ? sdm_pkg::SDM_S_RD : sdm_pkg::SDM_S_WR);
    end else if (take) begin
      unique case (st_r)
        sdm_pkg::SDM_S_IDLE: st_r <= sdm_pkg::SDM_S_IDLE;
        sdm_pkg::SDM_S_RD,
        sdm_pkg::SDM_S_WR:   st_r <= stop ? sdm_pkg::SDM_S_IDLE : st_r;
        default:             st_r <= sdm_pkg::SDM_S_IDLE;
      endcase
    end
  end

  // array has no reset: contents are undefined after power-up anyway
  always_ff @(posedge i_clk_sys) begin
    if (wr_beat) begin
      mem_r[idx] <= i_dq;
    end
  end

  // a write takes the pins at once, so queued read words are dropped
  sdm_buf2 #(
    .WIDTH (`SDM_DQ_W),
    .DEPTH (`SDM_BUF_DEPTH)
  ) u_buf (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_flush   (wr_go),
    .i_valid   (rd_push),
    .o_ready   (buf_rdy),
    .i_data    (mem_r[idx]),
    .o_valid   (buf_vld),
    .i_ready   (pop_rdy),
    .o_data    (buf_dat)
  );

  assign pop_rdy = take && (cl3 ? push_sr_r[1] : push_sr_r[0]);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      push_sr_r <= 2'h0;
    end else if (wr_go) begin
      push_sr_r <= 2'h0;
    end else if (take) begin
      push_sr_r <= {push_sr_r[0], rd_push && buf_rdy};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      dqm_d1_r <= 1'b1;
    end else begin
      dqm_d1_r <= i_dqm;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dq      <= 16'h0000;
      o_dq_oe_n <= 1'b1;
    end else if (wr_go) begin
      o_dq_oe_n <= 1'b1;
    end else if (take) begin
      o_dq_oe_n <= !(buf_vld && pop_rdy) || dqm_d1_r;
      if (buf_vld && pop_rdy) begin
        o_dq <= buf_dat;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  property p_lat2;
    rd_go && !cl3 && !i_dqm ##1 (i_cke && !wr_go) |=> !o_dq_oe_n;
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency two read not driven");

  property p_lat3;
    rd_go && cl3 ##1 (i_cke && !wr_go && !i_dqm) ##1 (i_cke && !wr_go)
      |=> !o_dq_oe_n;
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency three read not driven");

  property p_lat3_early;
    rd_go && cl3 && push_sr_r == 2'h0 && !buf_vld ##1 (i_cke && !wr_go)
      |=> o_dq_oe_n;
  endproperty
  a_lat3_early: assert property (p_lat3_early) else $error("read driven early");

  property p_mode_hold;
    !lmr_go |=> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

  property p_mode_load;
    lmr_go |=> mode_r.read_latency_field == $past(i_addr[6:4])
            && mode_r.burst_length_field == $past(i_addr[2:0])
            && mode_r.write_burst_single_bit == $past(i_addr[9]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode fields wrong");

  property p_closed;
    take && cmd == sdm_pkg::SDM_C_RD && !open_w[ba] && st_r == sdm_pkg::SDM_S_IDLE
      |=> st_r == sdm_pkg::SDM_S_IDLE;
  endproperty
  a_closed: assert property (p_closed) else $error("read to closed bank");

  property p_row;
    act_go |=> row_w[$past(ba)] == $past(i_addr) && open_w[$past(ba)];
  endproperty
  a_row: assert property (p_row) else $error("row not latched");

  property p_blen;
    wr_go && mode_r.burst_length_field == `SDM_BL_4 && !mode_r.write_burst_single_bit
      ##1 quiet[*3] |-> (st_r == sdm_pkg::SDM_S_WR)
      and (quiet |=> st_r == sdm_pkg::SDM_S_IDLE);
  endproperty
  a_blen: assert property (p_blen) else $error("burst of four wrong length");

  property p_wbs;
    wr_go && mode_r.write_burst_single_bit |=> st_r == sdm_pkg::SDM_S_IDLE;
  endproperty
  a_wbs: assert property (p_wbs) else $error("single write kept bursting");

  property p_ilv;
    wr_go && mode_r.burst_length_field == `SDM_BL_4 && mode_r.burst_order_bit
      && !mode_r.write_burst_single_bit && i_addr[1:0] == 2'h1
      ##1 quiet |-> cur_col[1:0] == 2'h0;
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleaved order wrong");

  property p_wrap;
    wr_go && mode_r.burst_length_field == `SDM_BL_4 && !mode_r.burst_order_bit
      && !mode_r.write_burst_single_bit && i_addr[1:0] == 2'h3
      ##1 quiet |-> cur_col == {$past(i_addr[7:2]), 2'h0};
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst left its block");

  property p_fpage;
    st_r == sdm_pkg::SDM_S_WR && fp_r && quiet ##1 quiet
      |-> st_r == sdm_pkg::SDM_S_WR && cur_col == 8'($past(cur_col) + 8'h01);
  endproperty
  a_fpage: assert property (p_fpage) else $error("full page step wrong");

  property p_test;
    take && cmd == sdm_pkg::SDM_C_RD && !normal && st_r == sdm_pkg::SDM_S_IDLE
      |=> st_r == sdm_pkg::SDM_S_IDLE;
  endproperty
  a_test: assert property (p_test) else $error("burst outside normal mode");

  c_rd3: cover property (rd_go && cl3 ##3 !o_dq_oe_n);
  c_full: cover property (wr_go && mode_r.burst_length_field == `SDM_BL_FULL);
  c_ilv_rd: cover property (rd_go && mode_r.burst_order_bit);
  c_stream: cover property (!o_dq_oe_n [*4]);
endmodule // sdm_core

// ==== tb/sdm_ctrl_model.sv ====
// memory controller model driving the command bus of the dram device
`timescale 1ns/1ps
module sdm_ctrl_model #(
  parameter int PWR_CYC = 5000
) (
  // clock
  input  wire logic          i_clk_sys,
  // command and address
  output logic               o_cke,
  output sdm_pkg::sdm_ctl_s  o_ctl,
  output logic               o_bank_select_low,
  output logic               o_bank_select_high,
  output logic [11:0]        o_addr,
  output logic               o_dqm,
  // write data
  output sdm_pkg::sdm_word_t o_dq
);
  initial begin
    o_cke              = 1'b1;
    o_dqm              = 1'b1;
    o_ctl              = sdm_pkg::sdm_ctl_s'(4'hF);
    o_bank_select_low  = 1'b0;
    o_bank_select_high = 1'b0;
    o_addr             = 12'h000;
    o_dq               = 16'hA5A5;
  end

  // one command a cycle, changed just after the edge, held over the next one
  task automatic step(input sdm_pkg::sdm_cmd_e c, input logic [1:0] ba, input logic [11:0] a,
                      input logic drv, input sdm_pkg::sdm_word_t d, input logic m);
    @(posedge i_clk_sys);
    #1;
    o_ctl              = sdm_pkg::sdm_ctl_s'({1'b0, c});
    o_bank_select_low  = ba[0];
    o_bank_select_high = ba[1];
    o_addr             = a;
    o_dqm              = m;
    // no pull on the data lines, so a released bus keeps changing
    o_dq               = drv ? d : ~o_dq;
  endtask

  task automatic nop(input logic m);
    step(sdm_pkg::SDM_C_NOP, 2'h0, 12'h000, 1'b0, 16'h0000, m);
  endtask

  task automatic power_up();
    repeat (PWR_CYC) nop(1'b1);
    step(sdm_pkg::SDM_C_PRE, 2'h0, 12'h400, 1'b0, 16'h0000, 1'b1);
    repeat (2) begin
      step(sdm_pkg::SDM_C_REF, 2'h0, 12'h000, 1'b0, 16'h0000, 1'b1);
      repeat (3) nop(1'b1);
    end
  endtask

  // closes every bank first, so the next access needs a fresh activate
  task automatic load_mode(input logic [11:0] mode);
    step(sdm_pkg::SDM_C_PRE, 2'h0, 12'h400, 1'b0, 16'h0000, 1'b0);
    step(sdm_pkg::SDM_C_LMR, 2'h0, mode, 1'b0, 16'h0000, 1'b0);
    nop(1'b0);
  endtask
endmodule // sdm_ctrl_model

// ==== tb/test_sdram_init_mode_burst.sv ====
// self-checking bench of the dram device against an associative array model
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_sdram_init_mode_burst;
  logic               clk_sys;
  logic               nrst;
  logic               cke;
  logic               bsl;
  logic               bsh;
  logic               dqm;
  logic               dq_oe_n;
  logic [11:0]        addr;
  sdm_pkg::sdm_ctl_s  ctl;
  sdm_pkg::sdm_word_t dq_w;
  sdm_pkg::sdm_word_t dq_r;
  sdm_pkg::sdm_word_t dq_bus;
  int                 bad_count;
  int                 checks_done;
  int                 cycles;
  int                 seed;
  int                 mem [int];
  int                 codes [5] = '{0, 1, 2, 3, 7};

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // resolved data wire: device wins while its enable is low
  assign dq_bus = dq_oe_n ? dq_w : dq_r;

  sdm_ctrl_model ctrl (
    .i_clk_sys          (clk_sys),
    .o_cke              (cke),
    .o_ctl              (ctl),
    .o_bank_select_low  (bsl),
    .o_bank_select_high (bsh),
    .o_addr             (addr),
    .o_dqm              (dqm),
    .o_dq               (dq_w)
  );

  sdm_core uut (
    .i_clk_sys          (clk_sys),
    .i_nrst             (nrst),
    .i_cke              (cke),
    .i_ctl              (ctl),
    .i_bank_select_low  (bsl),
    .i_bank_select_high (bsh),
    .i_addr             (addr),
    .i_dqm              (dqm),
    .i_dq               (dq_bus),
    .o_dq               (dq_r),
    .o_dq_oe_n          (dq_oe_n)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic int key(int ba, int row, int col);
    return (ba * 4096 + row) * 256 + col;
  endfunction

  function automatic int len_of(int code);
    case (code)
      0: return 1;
      1: return 2;
      2: return 4;
      3: return 8;
      default: return 256;
    endcase
  endfunction

  function automatic int col_of(int start, int len, int il, int k);
    int off;
    if (len == 256) return (start + k) % 256;
    off = start % len;
    return start - off + ((il != 0) ? (off ^ k) : ((off + k) % len));
  endfunction

  function automatic logic [11:0] mode_of(int ws, int opm, int cl, int il, int bc);
    return {2'b00, 1'(ws), 2'(opm), 3'(cl), 1'(il), 3'(bc)};
  endfunction

  task automatic open_row(input int ba, input int row);
    ctrl.step(sdm_pkg::SDM_C_ACT, 2'(ba), 12'(row), 1'b0, 16'h0000, 1'b0);
    repeat ($unsigned($random(seed)) % 3) ctrl.nop(1'b0);
  endtask

  // n beats driven; take clear when the device should refuse the write
  task automatic wr_burst(input int ba, input int row, input int col, input int len,
                          input int il, input int n, input bit take);
    int d;
    for (int k = 0; k < n; k++) begin
      d = $random(seed) & 16'hFFFF;
      ctrl.step((k == 0) ? sdm_pkg::SDM_C_WR : sdm_pkg::SDM_C_NOP, 2'(ba), 12'(col), 1'b1,
                16'(d), 1'b0);
      if (take) mem[key(ba, row, col_of(col, len, il, k))] = d;
    end
    if (len == 256) ctrl.step(sdm_pkg::SDM_C_BST, 2'h0, 12'h000, 1'b0, 16'h0000, 1'b0);
  endtask

  task automatic rd_burst(input int ba, input int row, input int col, input int len,
                          input int il, input int m, input int nchk);
    ctrl.step(sdm_pkg::SDM_C_RD, 2'(ba), 12'(col), 1'b0, 16'h0000, 1'b0);
    for (int j = 1; j <= m + nchk; j++) begin
      ctrl.step((len == 256 && j == nchk) ? sdm_pkg::SDM_C_BST : sdm_pkg::SDM_C_NOP,
                2'h0, 12'h000, 1'b0, 16'h0000, 1'b0);
      if (j == m - 1) `CHK("oe before data", 1'b1, dq_oe_n)
      else if (j >= m && j < m + nchk) begin
        `CHK("oe in burst", 1'b0, dq_oe_n)
        `CHK("read word", 16'(mem[key(ba, row, col_of(col, len, il, j - m))]), dq_r)
      end
      else if (len != 256) `CHK("oe after burst", 1'b1, dq_oe_n)
    end
  endtask

  task automatic rd_quiet(input int ba, input int col);
    ctrl.step(sdm_pkg::SDM_C_RD, 2'(ba), 12'(col), 1'b0, 16'h0000, 1'b0);
    repeat (6) begin
      ctrl.nop(1'b0);
      `CHK("refused read oe", 1'b1, dq_oe_n)
    end
  endtask

  initial begin
    int ba;
    int row;
    int col;
    int len;
    seed        = 32'h05061950;
    bad_count   = 0;
    checks_done = 0;
    cycles      = 0;
    nrst        = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    ctrl.power_up();
    // every length, order and latency, full page sequential only, at a random bank and row; full page starts at column 252
    foreach (codes[i]) begin
      for (int il = 0; il < 2; il++) begin
        for (int cl = 2; cl < 4; cl++) begin
          if (codes[i] == 7 && il == 1) continue;
          len = len_of(codes[i]);
          ba  = $random(seed) & 3;
          row = $random(seed) & 12'hFFF;
          // sequential starts with column bits 1..0 at 3, full page at 252, so every length wraps
          col = (len == 256) ? 252 : (($random(seed) & 8'hFF) | ((il == 0) ? 3 : 0));
          ctrl.load_mode(mode_of(0, 0, cl, il, codes[i]));
          open_row(ba, row);
          wr_burst(ba, row, col, len, il, (len == 256) ? 6 : len, 1'b1);
          rd_burst(ba, row, col, len, il, cl, (len == 256) ? 6 : len);
        end
      end
    end
    // single-location writes, then refusals in test mode and on a closed bank
    col = 8'h45;
    ctrl.load_mode(mode_of(0, 0, 2, 1, 2));
    open_row(ba, row);
    wr_burst(ba, row, col, 4, 1, 4, 1'b1);
    ctrl.load_mode(mode_of(1, 0, 2, 1, 2));
    open_row(ba, row);
    wr_burst(ba, row, col, 4, 1, 1, 1'b1);
    // idle beat with changing pins: a write that kept bursting would corrupt the block
    ctrl.nop(1'b0);
    rd_burst(ba, row, col, 4, 1, 2, 4);
    ctrl.load_mode(mode_of(0, 1, 2, 1, 2));
    open_row(ba, row);
    wr_burst(ba, row, col, 4, 1, 4, 1'b0);
    rd_quiet(ba, col);
    ctrl.load_mode(mode_of(0, 0, 3, 1, 2));
    rd_quiet(ba, col);
    open_row(ba, row);
    rd_burst(ba, row, col, 4, 1, 3, 4);
    give_verdict();
  end
endmodule // test_sdram_init_mode_burst
